// *** design/fsos_pkg.sv ***
// Purpose: constants and types for the frame sync output select block
// Assumes: 10 MHz core clock, 10-bit video words
// Notes:   counts above 4096 cycles are also top-level parameters
package fsos_pkg;

  // clock and time base
  localparam int CLK_HZ      = 10_000_000;
  localparam int US_CYC      = CLK_HZ / 1_000_000;
  localparam int MS_CYC      = CLK_HZ / 1_000;
  localparam int LOST_US     = 1000;
  localparam int LOST_CYC    = LOST_US * US_CYC;
  localparam int LINE_US     = 64;
  localparam int LINE_CYC    = LINE_US * US_CYC;
  localparam int FRAME_LINES = 1125;
  localparam int FRAME_CYC   = FRAME_LINES * LINE_CYC;
  localparam int REF_TMO_CYC = 2 * FRAME_CYC;

  // offset limits
  localparam int VOFS_LIM = 1124;
  localparam int HOFS_LIM = 64;

  // fifo shape
  localparam int FIFO_W  = 11;
  localparam int FIFO_D  = 16;
  localparam int SOF_BIT = 10;

  // video levels
  localparam logic [9:0] BLACK_LVL = 10'h040;
  localparam logic [9:0] WHITE_LVL = 10'h3ac;
  localparam logic [9:0] GREY_LO   = 10'h110;
  localparam logic [9:0] GREY_HI   = 10'h2f0;
  localparam logic [9:0] PLUGE_LO  = 10'h03c;
  localparam logic [9:0] PLUGE_HI  = 10'h044;

  // minimum latency caps per output format
  localparam logic [3:0] CAP_SD    = 4'h8;
  localparam logic [3:0] CAP_720   = 4'h6;
  localparam logic [3:0] CAP_1080  = 4'h4;
  localparam logic [3:0] CAP_3G    = 4'h2;

  // snow generator
  localparam logic [15:0] LFSR_SEED = 16'hace1;
  localparam logic [15:0] LFSR_TAPS = 16'hb400;

  typedef enum logic [2:0] {
    MODE_INPUT   = 3'b000,
    MODE_BLACK   = 3'b001,
    MODE_FREEZE  = 3'b010,
    MODE_PATTERN = 3'b011,
    MODE_SNOW    = 3'b100
  } fsos_mode_t;

  typedef enum logic [2:0] {
    LOST_DISABLE = 3'b000,
    LOST_BLACK   = 3'b001,
    LOST_FREEZE  = 3'b010,
    LOST_PATTERN = 3'b011,
    LOST_SNOW    = 3'b100
  } fsos_lost_t;

  function automatic int fsos_clamp(input int v, input int lim);
    fsos_clamp = (v > lim) ? lim : ((v < -lim) ? -lim : v);
  endfunction

endpackage

// *** design/fsos_stream_if.sv ***
// Purpose: stream carrier between the top and its fifo
// Assumes: valid/ready handshake on both sides
// Notes:   one producer/consumer user, one fifo
`timescale 1ns/1ps
interface fsos_stream_if #(parameter int W = 11);
  logic         wr_valid;
  logic         wr_ready;
  logic [W-1:0] wr_data;
  logic         rd_valid;
  logic         rd_ready;
  logic [W-1:0] rd_data;
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
endinterface

// *** design/fsos_fifo.sv ***
// Purpose: word fifo with registered head
// Assumes: single clock
// Notes:   holds DEPTH words in memory plus one in the head register
`timescale 1ns/1ps
module fsos_fifo #(
  parameter int W     = 11,
  parameter int DEPTH = 16
) (
  input  wire logic   i_clk,
  input  wire logic   i_reset_n,
  fsos_stream_if.fifo bus
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             cnt;
    logic                    hvalid;
    logic [W-1:0]            hdata;
  } fsos_fifo_state_t;

  fsos_fifo_state_t st_reg;
  fsos_fifo_state_t st_next;
  logic             push;
  logic             load;

  assign bus.wr_ready = (st_reg.cnt != (AW+1)'(DEPTH));
  assign bus.rd_valid = st_reg.hvalid;
  assign bus.rd_data  = st_reg.hdata;
  assign push         = bus.wr_valid && bus.wr_ready;
  assign load         = (!st_reg.hvalid || bus.rd_ready) && (st_reg.cnt != '0);

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wptr] = bus.wr_data;
      st_next.wptr             = st_reg.wptr + 1'b1;
    end
    if (bus.rd_ready && st_reg.hvalid) begin
      st_next.hvalid = 1'b0;
    end
    if (load) begin
      st_next.hdata  = st_reg.mem[st_reg.rptr];
      st_next.hvalid = 1'b1;
      st_next.rptr   = st_reg.rptr + 1'b1;
    end
    st_next.cnt = st_reg.cnt + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule // fsos_fifo

// *** design/fsos_top.sv ***
// Purpose: frame sync release and program output selection
// Assumes: video pins and reference are asynchronous to i_clk
// Notes:   freeze repeats the last word of the last valid frame
// Operation
// - output selector: input, black, freeze, pattern, snow
// - input mode passes buffered program video
// - black mode emits uniform black level
// - freeze repeats last word of frames with valid codes
// - pattern mode emits the selected pattern
// - snow mode emits noise from a generator
// - nine patterns, same choice for failover
// - lost input substitutes the configured action
// - disable action drops output enable when lost
// - offsets act only with sync enabled
// - vertical offset in lines, clamped to 1124
// - horizontal offset in microseconds, clamped to 64
// - negative offsets hold off the release
// - no release before minimum frames buffered, with sync enabled (one frame otherwise)
// - latency between minimum and minimum plus frame
// - minimum latency capped per output format
// - report delay in ms, frames and lines
// - report sync and scaler delay separately
// - report lock state and reference source
`timescale 1ns/1ps
module fsos_top #(
  parameter int P_LOST_CYC    = fsos_pkg::LOST_CYC,
  parameter int P_MS_CYC      = fsos_pkg::MS_CYC,
  parameter int P_FRAME_CYC   = fsos_pkg::FRAME_CYC,
  parameter int P_REF_TMO_CYC = fsos_pkg::REF_TMO_CYC
) (
  input  wire logic                i_clk,
  input  wire logic                i_reset_n,
  input  wire logic                i_vid_clk,
  input  wire logic [9:0]          i_vid_data,
  input  wire logic                i_vid_sof,
  input  wire logic                i_vid_code_ok,
  input  wire logic                i_ref_pulse,
  input  wire logic                i_sync_en,
  input  wire fsos_pkg::fsos_mode_t i_out_mode,
  input  wire fsos_pkg::fsos_lost_t i_lost_action,
  input  wire logic [3:0]          i_pattern_sel,
  input  wire logic signed [11:0]  i_voffset,
  input  wire logic signed [7:0]   i_hoffset,
  input  wire logic [3:0]          i_min_frames,
  input  wire logic [1:0]          i_out_format,
  input  wire logic [1:0]          i_ref_source,
  input  wire logic [15:0]         i_scaler_delay_ms,
  output logic                     o_in_ready,
  output logic [9:0]               o_pgm_data,
  output logic                     o_pgm_valid,
  output logic                     o_pgm_oe,
  output logic                     o_input_signal_lost,
  output logic                     o_locked,
  output logic [1:0]               o_ref_source_used,
  output logic [15:0]              o_delay_ms,
  output logic [15:0]              o_fs_delay_ms,
  output logic [15:0]              o_scaler_delay_ms,
  output logic [3:0]               o_delay_frames,
  output logic [11:0]              o_delay_lines,
  output logic [3:0]               o_eff_min_frames
);
  import fsos_pkg::*;

  typedef struct packed {
    logic        vclk_s1;
    logic        vclk_s2;
    logic        vclk_d;
    logic [11:0] vin_s1;
    logic [11:0] vin_s2;
    logic        ref_s1;
    logic        ref_s2;
    logic        ref_d;
    logic        lost;
    logic [31:0] lost_cnt;
    logic [31:0] ref_age;
    logic        armed;
    logic [31:0] hold_cnt;
    logic        reading;
    logic        popped_any;
    logic [3:0]  frames_buf;
    logic [9:0]  hpos;
    logic [15:0] lfsr;
    logic [9:0]  freeze_word;
    logic [9:0]  out_data;
    logic        out_valid;
    logic        out_oe;
    logic [31:0] ms_pre;
    logic [15:0] ms_cnt;
    logic [15:0] fs_ms;
    logic [15:0] tot_ms;
    logic [15:0] scl_ms;
    logic [3:0]  dly_frames;
    logic [11:0] dly_lines;
    logic        locked;
    logic [1:0]  ref_src;
  } fsos_state_t;

  fsos_state_t        st_reg;
  fsos_state_t        st_next;
  fsos_mode_t         eff_mode;
  logic               vclk_rise;
  logic               ref_rise;
  logic               push;
  logic               pop;
  logic               head_sof;
  logic               trigger;
  logic               release_now;
  logic [3:0]         eff_min;
  logic [3:0]         need;
  logic signed [31:0] v_cl;
  logic signed [31:0] h_cl;
  logic signed [31:0] tot_dly;

  fsos_stream_if #(.W(FIFO_W)) fifo_bus ();

  fsos_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .bus       (fifo_bus)
  );

  function automatic logic [3:0] fmt_cap(input logic [1:0] fmt);
    unique case (fmt)
      2'b00:   fmt_cap = CAP_SD;
      2'b01:   fmt_cap = CAP_720;
      2'b10:   fmt_cap = CAP_1080;
      2'b11:   fmt_cap = CAP_3G;
    endcase
  endfunction

  function automatic logic [9:0] pattern_word(input logic [3:0] sel, input logic [9:0] h);
    logic [2:0] bar;
    bar = h[9:7];
    unique case (sel)
      4'h0:    pattern_word = {2'b01, ~bar, 5'h00};
      4'h1:    pattern_word = {1'b1, ~bar, 6'h00};
      4'h2:    pattern_word = h[9] ? {2'b01, bar, 5'h00} : {1'b1, ~bar, 6'h00};
      4'h3:    pattern_word = (h[6] ^ h[8]) ? GREY_HI : GREY_LO;
      4'h4:    pattern_word = (h[9:8] == 2'b01) ? PLUGE_LO : ((h[9:8] == 2'b10) ? PLUGE_HI : BLACK_LVL);
      4'h5:    pattern_word = h;
      4'h6:    pattern_word = h ^ {h[8:0], 1'b0};
      4'h7:    pattern_word = (h[9:4] == 6'h00 || h[9]) ? WHITE_LVL : BLACK_LVL;
      4'h8:    pattern_word = h[4'({2'b00, h[9:8]}) + 4'h2] ? GREY_HI : GREY_LO;
      default: pattern_word = BLACK_LVL;
    endcase
  endfunction

  // offset and release timing
  always_comb begin
    v_cl    = fsos_clamp(int'(i_voffset), VOFS_LIM);
    h_cl    = fsos_clamp(int'(i_hoffset), HOFS_LIM);
    tot_dly = v_cl * LINE_CYC + h_cl * US_CYC;
    if (tot_dly < 0) begin
      tot_dly = tot_dly + P_FRAME_CYC;
    end
  end

  assign eff_min     = (i_min_frames > fmt_cap(i_out_format)) ? fmt_cap(i_out_format) : i_min_frames;
  assign need        = (i_sync_en && eff_min != 4'h0) ? eff_min : 4'h1;
  assign vclk_rise   = st_reg.vclk_s2 && !st_reg.vclk_d;
  assign ref_rise    = st_reg.ref_s2 && !st_reg.ref_d;
  assign head_sof    = fifo_bus.rd_data[SOF_BIT];
  assign trigger     = i_sync_en ? (st_reg.armed && st_reg.hold_cnt == 32'h0000_0000) : 1'b1;
  assign release_now = trigger && !st_reg.reading && fifo_bus.rd_valid && head_sof
                       && (st_reg.frames_buf >= need);

  // fifo handshake, back-pressure reaches the pins
  assign fifo_bus.wr_valid = vclk_rise;
  assign fifo_bus.wr_data  = st_reg.vin_s2[10:0];
  assign fifo_bus.rd_ready = st_reg.reading ? !(head_sof && st_reg.popped_any) : !head_sof;
  assign push              = fifo_bus.wr_valid && fifo_bus.wr_ready;
  assign pop               = fifo_bus.rd_valid && fifo_bus.rd_ready;
  assign o_in_ready        = fifo_bus.wr_ready;

  always_comb begin
    if (i_out_mode == MODE_INPUT && st_reg.lost && i_lost_action != LOST_DISABLE) begin
      eff_mode = fsos_mode_t'(i_lost_action);
    end else begin
      eff_mode = i_out_mode;
    end
  end

  always_comb begin
    st_next         = st_reg;
    st_next.vclk_s1 = i_vid_clk;
    st_next.vclk_s2 = st_reg.vclk_s1;
    st_next.vclk_d  = st_reg.vclk_s2;
    st_next.vin_s1  = {i_vid_code_ok, i_vid_sof, i_vid_data};
    st_next.vin_s2  = st_reg.vin_s1;
    st_next.ref_s1  = i_ref_pulse;
    st_next.ref_s2  = st_reg.ref_s1;
    st_next.ref_d   = st_reg.ref_s2;

    // loss of signal watch
    if (vclk_rise && st_reg.vin_s2[11]) begin
      st_next.lost_cnt = 32'h0000_0000;
      st_next.lost     = 1'b0;
    end else if (st_reg.lost_cnt < 32'(P_LOST_CYC)) begin
      st_next.lost_cnt = st_reg.lost_cnt + 32'h0000_0001;
    end else begin
      st_next.lost    = 1'b1;
    end

    // reference watch and lock
    if (ref_rise) begin
      st_next.ref_age = 32'h0000_0000;
    end else if (st_reg.ref_age < 32'(P_REF_TMO_CYC)) begin
      st_next.ref_age = st_reg.ref_age + 32'h0000_0001;
    end
    st_next.locked  = i_sync_en && (st_reg.ref_age < 32'(P_REF_TMO_CYC)) && !st_reg.lost;
    st_next.ref_src = i_ref_source;

    // offset hold-off after each reference edge
    if (!i_sync_en) begin
      st_next.armed = 1'b0;
    end else if (ref_rise) begin
      st_next.armed    = 1'b1;
      st_next.hold_cnt = 32'(tot_dly);
    end else if (st_reg.armed && st_reg.hold_cnt == 32'h0000_0000) begin
      st_next.armed = 1'b0;
    end else if (st_reg.armed) begin
      st_next.hold_cnt = st_reg.hold_cnt - 32'h0000_0001;
    end

    // frame release and end of frame
    if (release_now) begin
      st_next.reading    = 1'b1;
      st_next.popped_any = 1'b0;
      st_next.fs_ms      = st_reg.ms_cnt;
      st_next.dly_frames = st_reg.frames_buf;
      st_next.dly_lines  = (v_cl > 0) ? 12'(v_cl) : 12'h000;
    end else if (st_reg.reading && fifo_bus.rd_valid && head_sof && st_reg.popped_any) begin
      st_next.reading    = 1'b0;
      st_next.popped_any = 1'b0;
    end else if (pop && st_reg.reading) begin
      st_next.popped_any = 1'b1;
    end
    st_next.scl_ms = i_scaler_delay_ms;
    st_next.tot_ms = st_reg.fs_ms + st_reg.scl_ms;

    // frames held in the buffer
    st_next.frames_buf = st_reg.frames_buf
                         + 4'(push && fifo_bus.wr_data[SOF_BIT])
                         - 4'(pop && head_sof);

    // age of the oldest buffered frame in ms
    if (st_reg.frames_buf == 4'h0) begin
      st_next.ms_pre = 32'h0000_0000;
      st_next.ms_cnt = 16'h0000;
    end else if (st_reg.ms_pre >= 32'(P_MS_CYC - 1)) begin
      st_next.ms_pre = 32'h0000_0000;
      st_next.ms_cnt = st_reg.ms_cnt + 16'h0001;
    end else begin
      st_next.ms_pre = st_reg.ms_pre + 32'h0000_0001;
    end

    // freeze store only from frames with valid codes
    if (pop && st_reg.reading && !st_reg.lost) begin
      st_next.freeze_word = fifo_bus.rd_data[9:0];
    end

    // generators
    st_next.hpos = st_reg.hpos + 10'h001;
    st_next.lfsr = st_reg.lfsr[0] ? ((st_reg.lfsr >> 1) ^ LFSR_TAPS) : (st_reg.lfsr >> 1);

    // program output
    st_next.out_oe    = 1'b1;
    st_next.out_valid = 1'b1;
    unique case (eff_mode)
      MODE_INPUT: begin
        if (st_reg.lost) begin
          st_next.out_oe    = 1'b0;
          st_next.out_valid = 1'b0;
        end else begin
          st_next.out_valid = pop && st_reg.reading;
          if (pop && st_reg.reading) begin
            st_next.out_data = fifo_bus.rd_data[9:0];
          end
        end
      end
      MODE_BLACK: begin
        st_next.out_data = BLACK_LVL;
      end
      MODE_FREEZE: begin
        st_next.out_data = st_reg.freeze_word;
      end
      MODE_PATTERN: begin
        st_next.out_data = pattern_word(i_pattern_sel, st_reg.hpos);
      end
      MODE_SNOW: begin
        st_next.out_data = st_reg.lfsr[9:0];
      end
      default: begin
        st_next.out_data  = BLACK_LVL;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_reg          <= '0;
      st_reg.lfsr     <= LFSR_SEED;
      st_reg.out_data <= BLACK_LVL;
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_pgm_data          = st_reg.out_data;
  assign o_pgm_valid         = st_reg.out_valid;
  assign o_pgm_oe            = st_reg.out_oe;
  assign o_input_signal_lost = st_reg.lost;
  assign o_locked            = st_reg.locked;
  assign o_ref_source_used   = st_reg.ref_src;
  assign o_delay_ms          = st_reg.tot_ms;
  assign o_fs_delay_ms       = st_reg.fs_ms;
  assign o_scaler_delay_ms   = st_reg.scl_ms;
  assign o_delay_frames      = st_reg.dly_frames;
  assign o_delay_lines       = st_reg.dly_lines;
  assign o_eff_min_frames    = eff_min;

  // checks
  AST_LOST_SET: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(st_reg.lost) |-> $past(st_reg.lost_cnt) == 32'(P_LOST_CYC))
    else $error("loss flag set at wrong count");

  AST_BLACK: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $past(i_out_mode) == MODE_BLACK && $past(i_reset_n) |-> st_reg.out_data == BLACK_LVL && st_reg.out_valid)
    else $error("black mode not black");

  AST_DISABLE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $past(i_out_mode == MODE_INPUT && st_reg.lost && i_lost_action == LOST_DISABLE) |-> !o_pgm_oe)
    else $error("output still enabled while lost");

  AST_SNOW: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $past(eff_mode) == MODE_SNOW |-> st_reg.out_data == $past(st_reg.lfsr[9:0]))
    else $error("snow word mismatch");

  AST_FREEZE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $past(eff_mode) == MODE_FREEZE ##1 $past(eff_mode) == MODE_FREEZE
      |-> $stable(st_reg.out_data) || $past(pop && st_reg.reading, 2))
    else $error("freeze output wandered");

  AST_MIN_LAT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(st_reg.reading) |-> $past(st_reg.frames_buf) >= $past(need) && $past(need) >= 4'h1)
    else $error("frame released below minimum latency");

  AST_CAP: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    eff_min <= fmt_cap(i_out_format) && eff_min <= i_min_frames)
    else $error("minimum latency above format cap");

  AST_OFS_OFF: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !$past(i_sync_en) |-> !st_reg.armed)
    else $error("offset armed without sync");

  AST_HOLD_LOAD: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (ref_rise && i_sync_en) |=> st_reg.armed && st_reg.hold_cnt == 32'($past(tot_dly)))
    else $error("hold-off count not loaded");

  AST_REPORT: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    $rose(st_reg.reading) |-> st_reg.dly_frames == $past(st_reg.frames_buf) ##2
      o_delay_ms == o_fs_delay_ms + $past(i_scaler_delay_ms, 2))
    else $error("delay report not latched");

endmodule // fsos_top

// *** verif/fsos_video_src.sv ***
// Purpose: program video source and house reference model
// Assumes: 800 ns word clock, made only within frames
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ps
module fsos_video_src (
  input  wire logic  i_clk,
  output logic       o_vid_clk,
  output logic [9:0] o_vid_data,
  output logic       o_vid_sof,
  output logic       o_vid_code_ok,
  output logic       o_ref_pulse
);
  initial begin
    o_vid_clk = 1'h0;
    o_vid_data = 10'h000;
    o_vid_sof = 1'h0;
    o_vid_code_ok = 1'h0;
    o_ref_pulse = 1'h0;
  end
  // one word, held 400 ns each side of the rise
  task automatic word(input logic [9:0] w, input logic s);
    o_vid_data <= w;
    o_vid_sof <= s;
    o_vid_code_ok <= 1'h1;
    repeat (4) @(negedge i_clk);
    o_vid_clk <= 1'h1;
    repeat (4) @(negedge i_clk);
    o_vid_clk <= 1'h0;
  endtask
  task automatic release_lines();
    o_vid_data <= ~o_vid_data;
    o_vid_sof <= ~o_vid_sof;
    o_vid_code_ok <= ~o_vid_code_ok;
  endtask
  task automatic ref_tick();
    o_ref_pulse <= 1'h1;
    repeat (4) @(negedge i_clk);
    o_ref_pulse <= 1'h0;
  endtask
endmodule // fsos_video_src

// *** verif/tb_framesync_output_select.sv ***
// Purpose: self-checking bench for the output select block
// Assumes: shortened counts handed down as parameters
// Notes:   monitor compares released words against a queue
`timescale 1ns/1ps
module tb_framesync_output_select;
  import fsos_pkg::*;
  localparam int LOSC = 50;
  logic       clk, rst_n, sync_en, vclk, vsof, vok, refp;
  logic       rdy, valid, oe, lost, locked, prev_lost;
  fsos_mode_t mode;
  fsos_lost_t act;
  logic [3:0] pat, minf, dfr, effm;
  logic [1:0] fmt, rsrc, rused;
  logic [9:0] vdat, data;
  logic signed [11:0] vofs;
  logic signed [7:0]  hofs;
  logic [11:0] dln;
  logic [15:0] scal, dms, fms, sms, seed;
  logic [9:0] exp_q[$];
  logic [3:0] caps[4] = '{CAP_SD, CAP_720, CAP_1080, CAP_3G};
  int         err_total, n_tests, n_out;

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  fsos_top #(.P_LOST_CYC(LOSC), .P_MS_CYC(10), .P_FRAME_CYC(2000), .P_REF_TMO_CYC(4000)) dut_u (
    .i_clk(clk), .i_reset_n(rst_n), .i_vid_clk(vclk), .i_vid_data(vdat),
    .i_vid_sof(vsof), .i_vid_code_ok(vok), .i_ref_pulse(refp), .i_sync_en(sync_en),
    .i_out_mode(mode), .i_lost_action(act), .i_pattern_sel(pat), .i_voffset(vofs),
    .i_hoffset(hofs), .i_min_frames(minf), .i_out_format(fmt), .i_ref_source(rsrc),
    .i_scaler_delay_ms(scal), .o_in_ready(rdy), .o_pgm_data(data), .o_pgm_valid(valid),
    .o_pgm_oe(oe), .o_input_signal_lost(lost), .o_locked(locked), .o_ref_source_used(rused),
    .o_delay_ms(dms), .o_fs_delay_ms(fms), .o_scaler_delay_ms(sms), .o_delay_frames(dfr),
    .o_delay_lines(dln), .o_eff_min_frames(effm));

  fsos_video_src src_u (.i_clk(clk), .o_vid_clk(vclk), .o_vid_data(vdat), .o_vid_sof(vsof),
    .o_vid_code_ok(vok), .o_ref_pulse(refp));

  function automatic void step();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
  endfunction

  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic frame(input bit note);
    for (int i = 0; i < 4; i++) begin
      step();
      if (note) exp_q.push_back(seed[9:0]);
      src_u.word(seed[9:0], i == 0);
    end
  endtask

  task automatic wait_q();
    repeat (200) if (exp_q.size() > 0) @(negedge clk);
    chk(16'h0000, exp_q.size());
  endtask

  task automatic report_and_stop();
    $display("mismatches=%0d comparisons=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // released words of the input path
  always @(negedge clk) begin
    if (valid === 1'h1 && lost === 1'h0 && prev_lost === 1'h0 && mode === MODE_INPUT) begin
      n_out++;
      if (exp_q.size() > 0) chk(exp_q.pop_front(), data);
    end
    prev_lost <= lost;
  end

  initial begin
    repeat (10000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  initial begin
    int k;
    logic [9:0] last;
    seed = 16'he0d7;
    rst_n = 1'h0;
    sync_en = 1'h0;
    mode = MODE_BLACK;
    act = LOST_DISABLE;
    {pat, minf, fmt, rsrc, scal, vofs, hofs} = '0;
    {err_total, n_tests, n_out} = '0;
    repeat (3) @(negedge clk);
    chk(BLACK_LVL, data);
    chk(16'h0001, rdy);
    rst_n = 1'h1;
    repeat (3) @(negedge clk);
    chk(BLACK_LVL, data);
    chk(16'h0001, valid);
    step();
    scal = seed;
    rsrc = 2'h2;
    repeat (2) @(negedge clk);
    chk(rsrc, rused);
    chk(scal, sms);
    for (int f = 0; f < 4; f++) begin
      fmt = f[1:0];
      step();
      minf = seed[3:0];
      @(negedge clk);
      chk((minf < caps[f]) ? minf : caps[f], effm);
    end
    mode = MODE_PATTERN;
    for (int p = 0; p < 10; p++) begin
      pat = p[3:0];
      repeat (2) @(negedge clk);
      chk(16'h0001, valid);
      if (p > 8) chk(BLACK_LVL, data);
    end
    mode = MODE_SNOW;
    k = 0;
    repeat (16) begin
      last = data;
      @(negedge clk);
      if (data !== last) k++;
    end
    chk(16'h0001, k > 8);
    mode = MODE_INPUT;
    repeat (LOSC + 10) @(negedge clk);
    chk(16'h0001, lost);
    chk(16'h0000, oe);
    for (int a = 1; a < 5; a++) begin
      act = fsos_lost_t'(a);
      repeat (2) @(negedge clk);
      chk(16'h0001, oe);
      chk(16'h0001, valid);
    end
    act = LOST_BLACK;
    vofs = 12'sh005;
    repeat (2) @(negedge clk);
    chk(BLACK_LVL, data);
    frame(1);
    frame(0);
    src_u.release_lines();
    chk(16'h0000, lost);
    wait_q();
    mode = MODE_FREEZE;
    repeat (3) @(negedge clk);
    chk(seed[9:0], data);
    rst_n = 1'h0;
    mode = MODE_INPUT;
    vofs = 12'shffd;
    hofs = 8'shfa;
    repeat (3) @(negedge clk);
    rst_n = 1'h1;
    sync_en = 1'h1;
    minf = 4'h2;
    fmt = 2'h0;
    repeat (3) @(negedge clk);
    n_out = 0;
    frame(1);
    src_u.release_lines();
    src_u.ref_tick();
    repeat (20) @(negedge clk);
    chk(16'h0000, n_out);
    frame(0);
    frame(0);
    src_u.release_lines();
    src_u.ref_tick();
    repeat (10) @(negedge clk);
    chk(16'h0000, n_out);
    wait_q();
    chk(16'h0001, locked);
    chk(16'h0001, dfr >= minf && dfr <= minf + 4'h1);
    chk(scal, dms - fms);
    chk(16'h0000, dln);
    report_and_stop();
  end
endmodule // tb_framesync_output_select
